// ===== rtl/dao_defines.svh
// Timing counts and field layout of the dual converter output timing block
`ifndef DAO_DEFINES_SVH
`define DAO_DEFINES_SVH
`define DAO_DATA_WIDTH     10
`define DAO_MSB_POS        9
`define DAO_RATE_DIV       2
`define DAO_LATENCY_CYC    12
`define DAO_PIPE_DEPTH     (`DAO_LATENCY_CYC / `DAO_RATE_DIV)
`define DAO_CAL_MIN_CYC    10000
`define DAO_CAL_CNT_W      14
`define DAO_RESYNC_CYC     2
`define DAO_DISCARD_W      4
`endif

// ===== rtl/dao_device.sv
// Converter end: sequencing, latency pipeline, output formatting and calibration
`timescale 1ns/1ps
`include "dao_defines.svh"

module dao_device #(
    parameter int DATA_W     = `DAO_DATA_WIDTH,        // Data bits per channel
    parameter int PIPE_DEPTH = `DAO_PIPE_DEPTH,        // Samples in flight
    parameter int CAL_CYCLES = `DAO_CAL_MIN_CYC        // Power-up calibration length
) (
    input  wire logic          ref_clk,
    input  wire logic          resetn,
    dao_if.device              pins,
    input  wire logic [DATA_W-1:0] chan_a_level,
    input  wire logic          chan_a_above_fs,
    input  wire logic [DATA_W-1:0] chan_b_level,
    input  wire logic          chan_b_above_fs,
    output logic               cal_done,
    output logic               cal_step
);

    // Overrange clamp and sign format applied to one raw sample
    function automatic dao_pkg::dao_word_t fmt_word(
        input logic [DATA_W-1:0] level,
        input logic              above,
        input logic              twos
    );
        dao_pkg::dao_word_t w;
        w.over = above;
        w.bits = above ? {DATA_W{1'b1}} : level;
        w.bits[`DAO_MSB_POS] = w.bits[`DAO_MSB_POS] ^ twos;
        return w;
    endfunction : fmt_word

    // Sequencing state
    dao_pkg::dao_phase_t phase;                      // Current phase
    dao_pkg::dao_phase_t next_phase;
    logic                strobe_q;                   // Registered strobe
    logic                next_strobe_q;

    // Sample pipelines, one slot per sample in flight
    dao_pkg::dao_word_t  pipe_a [PIPE_DEPTH];
    dao_pkg::dao_word_t  pipe_b [PIPE_DEPTH];
    dao_pkg::dao_word_t  next_pipe_a [PIPE_DEPTH];
    dao_pkg::dao_word_t  next_pipe_b [PIPE_DEPTH];

    // Output word registers
    dao_pkg::dao_word_t  out_a;
    dao_pkg::dao_word_t  out_b;
    dao_pkg::dao_word_t  next_out_a;
    dao_pkg::dao_word_t  next_out_b;
    logic                oe;                         // Registered output enable
    logic                next_oe;

    // Calibration state
    logic [`DAO_CAL_CNT_W-1:0] cal_count;            // Cycles since power-up
    logic [`DAO_CAL_CNT_W-1:0] next_cal_count;
    logic                cal_done_q;
    logic                next_cal_done_q;
    logic                cal_step_q;                 // Background step toggle
    logic                next_cal_step_q;

    // Sequencing and pipeline next values
    always_comb
    begin
        next_phase    = phase;
        next_strobe_q = strobe_q;
        next_out_a    = out_a;
        next_out_b    = out_b;
        next_pipe_a   = pipe_a;
        next_pipe_b   = pipe_b;
        if (pins.conv_reset)
        begin
            // Suspend updates, re-arm on sample phase
            next_phase    = dao_pkg::DAO_HELD;
            next_strobe_q = 1'b0;
        end
        else
        begin
            case (phase)
                dao_pkg::DAO_HELD,
                dao_pkg::DAO_SAMPLE:
                begin
                    // Sample both channels, shift, present oldest
                    next_out_a     = pipe_a[PIPE_DEPTH-1];
                    next_out_b     = pipe_b[PIPE_DEPTH-1];
                    for (int i = PIPE_DEPTH-1; i > 0; i--)
                    begin
                        next_pipe_a[i] = pipe_a[i-1];
                        next_pipe_b[i] = pipe_b[i-1];
                    end
                    next_pipe_a[0] = fmt_word(chan_a_level, chan_a_above_fs, pins.sign_format_select);
                    next_pipe_b[0] = fmt_word(chan_b_level, chan_b_above_fs, pins.sign_format_select);
                    next_strobe_q  = 1'b0;
                    next_phase     = dao_pkg::DAO_STROBE;
                end
                dao_pkg::DAO_STROBE:
                begin
                    // Mark the stable word pair
                    next_strobe_q = 1'b1;
                    next_phase    = dao_pkg::DAO_SAMPLE;
                end
                default:
                begin
                    next_phase    = dao_pkg::DAO_HELD;
                    next_strobe_q = 1'b0;
                end
            endcase
        end
        next_oe = ~pins.output_hiz;
    end

    // Sequencing registers, rising edge only
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            phase    <= dao_pkg::DAO_HELD;
            strobe_q <= 1'b0;
            out_a    <= '0;
            out_b    <= '0;
            oe       <= 1'b0;
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                pipe_a[i] <= '0;
                pipe_b[i] <= '0;
            end
        end
        else
        begin
            phase    <= next_phase;
            strobe_q <= next_strobe_q;
            out_a    <= next_out_a;
            out_b    <= next_out_b;
            oe       <= next_oe;
            pipe_a   <= next_pipe_a;
            pipe_b   <= next_pipe_b;
        end
    end

    // Calibration next values, one step per clock edge
    always_comb
    begin
        next_cal_count  = cal_count;
        next_cal_done_q = cal_done_q;
        next_cal_step_q = ~cal_step_q;
        if (cal_count < `DAO_CAL_CNT_W'(CAL_CYCLES))
        begin
            next_cal_count = cal_count + `DAO_CAL_CNT_W'(1);
        end
        else
        begin
            next_cal_done_q = 1'b1;
        end
    end

    // Calibration registers
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            cal_count  <= '0;
            cal_done_q <= 1'b0;
            cal_step_q <= 1'b0;
        end
        else
        begin
            cal_count  <= next_cal_count;
            cal_done_q <= next_cal_done_q;
            cal_step_q <= next_cal_step_q;
        end
    end

    // Pin drive; strobe is gated by reset without waiting for an edge
    assign pins.sample_strobe            = strobe_q & ~pins.conv_reset;
    assign pins.chan_a_sample_bits_o     = out_a.bits;
    assign pins.chan_b_sample_bits_o     = out_b.bits;
    assign pins.chan_a_over_full_scale_o = out_a.over;
    assign pins.chan_b_over_full_scale_o = out_b.over;
    assign pins.data_oe                  = oe;
    assign cal_done                      = cal_done_q;
    assign cal_step                      = cal_step_q;

endmodule : dao_device

// ===== rtl/dao_host.sv
// Host end: drives reset and format pins, captures and qualifies word pairs
`timescale 1ns/1ps
`include "dao_defines.svh"

module dao_host #(
    parameter int CAL_CYCLES = `DAO_CAL_MIN_CYC        // Clocks before results count as calibrated
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    dao_if.host              pins,
    input  wire logic        resync_req,     // Pulse: re-phase the converter
    input  wire logic        twos_mode,      // Level: request two's complement
    input  wire logic        float_outputs,  // Level: float converter outputs
    output logic [9:0]       cap_a_bits,
    output logic             cap_a_over,
    output logic [9:0]       cap_b_bits,
    output logic             cap_b_over,
    output logic             cap_valid,      // Pulse: new valid word pair
    output logic             cap_calibrated
);

    // Host state
    dao_pkg::dao_host_state_t state;
    dao_pkg::dao_host_state_t next_state;
    logic [`DAO_DISCARD_W-1:0] count;              // Hold or discard counter
    logic [`DAO_DISCARD_W-1:0] next_count;
    logic                      rst_q;              // Reset pin drive
    logic                      next_rst_q;
    logic                      strobe_prev;        // Strobe one cycle ago
    logic [9:0]                a_bits, b_bits, next_a_bits, next_b_bits;
    logic                      a_over, b_over, next_a_over, next_b_over;
    logic                      valid_q, next_valid_q;
    logic                      fmt_q, hiz_q;
    logic [`DAO_CAL_CNT_W-1:0] cal_count, next_cal_count;
    logic                      cal_q, next_cal_q;
    logic                      rise;

    // Capture and sequencing next values
    always_comb
    begin
        rise         = pins.sample_strobe & ~strobe_prev;
        next_state   = state;
        next_count   = count;
        next_rst_q   = 1'b0;
        next_a_bits  = a_bits;
        next_b_bits  = b_bits;
        next_a_over  = a_over;
        next_b_over  = b_over;
        next_valid_q = 1'b0;
        if (rise)
        begin
            next_a_bits = pins.chan_a_sample_bits;
            next_b_bits = pins.chan_b_sample_bits;
            next_a_over = pins.chan_a_over_full_scale;
            next_b_over = pins.chan_b_over_full_scale;
        end
        case (state)
            dao_pkg::DAO_H_IDLE,
            dao_pkg::DAO_H_RUN:
            begin
                next_valid_q = rise && (state == dao_pkg::DAO_H_RUN);
                if (resync_req)
                begin
                    next_state = dao_pkg::DAO_H_RESYNC;
                    next_count = `DAO_DISCARD_W'(`DAO_RESYNC_CYC);
                    next_rst_q = 1'b1;
                end
            end
            dao_pkg::DAO_H_RESYNC:
            begin
                // Hold reset high for a fixed count
                if (count > `DAO_DISCARD_W'(1))
                begin
                    next_rst_q = 1'b1;
                    next_count = count - `DAO_DISCARD_W'(1);
                end
                else
                begin
                    next_state = dao_pkg::DAO_H_DISCARD;
                    next_count = `DAO_DISCARD_W'(`DAO_PIPE_DEPTH);
                end
            end
            dao_pkg::DAO_H_DISCARD:
            begin
                // Drop words from the latency window
                if (rise)
                begin
                    next_count = count - `DAO_DISCARD_W'(1);
                    if (count == `DAO_DISCARD_W'(1))
                    begin
                        next_state = dao_pkg::DAO_H_RUN;
                    end
                end
            end
            default:
            begin
                next_state = dao_pkg::DAO_H_IDLE;
            end
        endcase
        // Results count as calibrated after the power-up window
        next_cal_count = cal_count;
        next_cal_q     = cal_q;
        if (cal_count < `DAO_CAL_CNT_W'(CAL_CYCLES))
        begin
            next_cal_count = cal_count + `DAO_CAL_CNT_W'(1);
        end
        else
        begin
            next_cal_q = 1'b1;
        end
    end

    // Host registers; clock is never gated
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state       <= dao_pkg::DAO_H_IDLE;
            count       <= '0;
            rst_q       <= 1'b0;
            strobe_prev <= 1'b0;
            a_bits      <= '0;
            b_bits      <= '0;
            a_over      <= 1'b0;
            b_over      <= 1'b0;
            valid_q     <= 1'b0;
            fmt_q       <= 1'b0;
            hiz_q       <= 1'b0;
            cal_count   <= '0;
            cal_q       <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            count       <= next_count;
            rst_q       <= next_rst_q;
            strobe_prev <= pins.sample_strobe;
            a_bits      <= next_a_bits;
            b_bits      <= next_b_bits;
            a_over      <= next_a_over;
            b_over      <= next_b_over;
            valid_q     <= next_valid_q;
            fmt_q       <= twos_mode;
            hiz_q       <= float_outputs;
            cal_count   <= next_cal_count;
            cal_q       <= next_cal_q;
        end
    end

    // Pin and user outputs
    assign pins.conv_reset         = rst_q;
    assign pins.sign_format_select = fmt_q;
    assign pins.output_hiz         = hiz_q;
    assign cap_a_bits              = a_bits;
    assign cap_a_over              = a_over;
    assign cap_b_bits              = b_bits;
    assign cap_b_over              = b_over;
    assign cap_valid               = valid_q;
    assign cap_calibrated          = cal_q;

endmodule : dao_host

// ===== rtl/dao_if.sv
// Pin-level link between the converter and its host capture logic
`timescale 1ns/1ps
interface dao_if;
    logic                 conv_reset;              // Host: high re-phases sequencing
    logic                 sign_format_select;      // Host: high gives two's complement
    logic                 output_hiz;              // Host: high floats data outputs
    logic                 sample_strobe;           // Device: data-valid strobe
    logic [9:0]           chan_a_sample_bits_o;    // Device: channel A data driven
    logic [9:0]           chan_b_sample_bits_o;    // Device: channel B data driven
    logic                 chan_a_over_full_scale_o; // Device: channel A overrange driven
    logic                 chan_b_over_full_scale_o; // Device: channel B overrange driven
    logic                 data_oe;                 // Device: high while data drives pins
    wire  [9:0]           chan_a_sample_bits;      // Resolved pin levels
    wire  [9:0]           chan_b_sample_bits;
    wire                  chan_a_over_full_scale;
    wire                  chan_b_over_full_scale;

    // Resolve pins from the output enable; floated pins show the inverse of the
    // drive, so a capture taken while floated never matches the driven word
    assign chan_a_sample_bits     = data_oe ? chan_a_sample_bits_o : ~chan_a_sample_bits_o;
    assign chan_b_sample_bits     = data_oe ? chan_b_sample_bits_o : ~chan_b_sample_bits_o;
    assign chan_a_over_full_scale = data_oe ? chan_a_over_full_scale_o : ~chan_a_over_full_scale_o;
    assign chan_b_over_full_scale = data_oe ? chan_b_over_full_scale_o : ~chan_b_over_full_scale_o;

    modport device (
        input  conv_reset,
        input  sign_format_select,
        input  output_hiz,
        output sample_strobe,
        output chan_a_sample_bits_o,
        output chan_b_sample_bits_o,
        output chan_a_over_full_scale_o,
        output chan_b_over_full_scale_o,
        output data_oe
    );

    modport host (
        output conv_reset,
        output sign_format_select,
        output output_hiz,
        input  sample_strobe,
        input  chan_a_sample_bits,
        input  chan_b_sample_bits,
        input  chan_a_over_full_scale,
        input  chan_b_over_full_scale
    );
endinterface : dao_if

// ===== rtl/dao_pkg.sv
// Types shared by both ends of the dual converter output timing link
package dao_pkg;
    // One converted channel word: overrange flag above ten data bits
    typedef struct packed {
        logic       over;
        logic [9:0] bits;
    } dao_word_t;

    // Device sequencing phase
    typedef enum logic [1:0] {
        DAO_HELD,
        DAO_SAMPLE,
        DAO_STROBE
    } dao_phase_t;

    // Host capture states
    typedef enum logic [1:0] {
        DAO_H_IDLE,
        DAO_H_RESYNC,
        DAO_H_DISCARD,
        DAO_H_RUN
    } dao_host_state_t;
endpackage : dao_pkg

// ===== verification/dao_link_asserts.sv
// Pin-level timing assertions for the converter-to-host link
`timescale 1ns/1ps
module dao_link_asserts (
    input wire logic       ref_clk,                  // Sampling clock
    input wire logic       resetn,                   // Synchronous reset, active low
    input wire logic       conv_reset,               // Host re-phase pin
    input wire logic       output_hiz,               // Host float request pin
    input wire logic       sample_strobe,            // Data-valid strobe
    input wire logic [9:0] chan_a_sample_bits_o,     // Channel A data as driven
    input wire logic [9:0] chan_b_sample_bits_o,     // Channel B data as driven
    input wire logic       chan_a_over_full_scale_o, // Channel A overrange as driven
    input wire logic       chan_b_over_full_scale_o, // Channel B overrange as driven
    input wire logic       data_oe                   // Data pin drive enable
);
    // Both channel words joined, so one check covers the pair
    logic [21:0] word_pair;
    assign word_pair = {chan_a_over_full_scale_o, chan_a_sample_bits_o,
                        chan_b_over_full_scale_o, chan_b_sample_bits_o};

    // One clock domain for every property
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // Release of the re-phase pin
    sequence resync_end_s;
        $fell(conv_reset);
    endsequence

    // Strobe low for two clocks, then high for one, then low
    sequence strobe_restart_s;
        !sample_strobe ##1 !sample_strobe ##1 sample_strobe ##1 !sample_strobe;
    endsequence

    strobe_reset_low_a: assert property (conv_reset |-> !sample_strobe)
        else $error("strobe high while re-phase pin high");
    data_frozen_a: assert property ($past(conv_reset) |-> $stable(word_pair))
        else $error("output words changed during re-phase");
    first_strobe_a: assert property (resync_end_s |-> strobe_restart_s)
        else $error("first strobe after re-phase at wrong edge");
    strobe_fall_a: assert property (sample_strobe |=> !sample_strobe)
        else $error("strobe high longer than one clock");
    strobe_rise_a: assert property ($past(sample_strobe) && !sample_strobe && !conv_reset
        |=> sample_strobe || conv_reset)
        else $error("strobe low longer than one clock");
    data_stands_a: assert property (!$stable(word_pair) |-> !sample_strobe)
        else $error("output words changed while strobe high");
    over_ones_a: assert property (chan_a_over_full_scale_o || chan_b_over_full_scale_o
        |-> (!chan_a_over_full_scale_o || chan_a_sample_bits_o[8:0] == 9'h1ff)
         && (!chan_b_over_full_scale_o || chan_b_sample_bits_o[8:0] == 9'h1ff))
        else $error("overrange word not all ones");
    drive_enable_a: assert property ($past(resetn) |-> data_oe == !$past(output_hiz))
        else $error("drive enable does not follow float request");
endmodule : dao_link_asserts

// ===== verification/tb_top.sv
// Self-checking bench joining converter and host ends over the pin link
`timescale 1ns/1ps
module tb_top;
    localparam int CAL_LEN = 20;        // Shortened power-up calibration
    logic       ref_clk = 1'b0;         // Bench clock, 50 ns period
    logic       resetn = 1'b0;          // Held low at start
    logic       resync_req = 1'b0;      // Host re-phase request
    logic       twos_mode = 1'b0;       // Format request
    logic       float_outputs = 1'b0;   // Float request
    logic [9:0] chan_a_level = 10'h000; // Channel A raw code
    logic       chan_a_above_fs = 1'b0; // Channel A overrange
    logic [9:0] chan_b_level = 10'h000; // Channel B raw code
    logic       chan_b_above_fs = 1'b0; // Channel B overrange
    logic       cal_done;               // Device calibration finished
    logic       cal_step;               // Device background step
    logic [9:0] cap_a_bits;             // Captured channel A
    logic       cap_a_over;
    logic [9:0] cap_b_bits;             // Captured channel B
    logic       cap_b_over;
    logic       cap_valid;              // New valid pair
    logic       cap_calibrated;         // Host calibration wait over
    int         fail_count = 0;         // Mismatches seen
    int         checks_done = 0;        // Comparisons made

    dao_if dao_if_inst ();

    dao_device #(.CAL_CYCLES(CAL_LEN)) dao_device_inst (
        .ref_clk(ref_clk), .resetn(resetn), .pins(dao_if_inst),
        .chan_a_level(chan_a_level), .chan_a_above_fs(chan_a_above_fs),
        .chan_b_level(chan_b_level), .chan_b_above_fs(chan_b_above_fs),
        .cal_done(cal_done), .cal_step(cal_step));

    dao_host #(.CAL_CYCLES(CAL_LEN)) dao_host_inst (
        .ref_clk(ref_clk), .resetn(resetn), .pins(dao_if_inst), .resync_req(resync_req),
        .twos_mode(twos_mode), .float_outputs(float_outputs), .cap_a_bits(cap_a_bits),
        .cap_a_over(cap_a_over), .cap_b_bits(cap_b_bits), .cap_b_over(cap_b_over),
        .cap_valid(cap_valid), .cap_calibrated(cap_calibrated));

    dao_link_asserts dao_link_asserts_inst (
        .ref_clk(ref_clk), .resetn(resetn), .conv_reset(dao_if_inst.conv_reset),
        .output_hiz(dao_if_inst.output_hiz), .sample_strobe(dao_if_inst.sample_strobe),
        .chan_a_sample_bits_o(dao_if_inst.chan_a_sample_bits_o),
        .chan_b_sample_bits_o(dao_if_inst.chan_b_sample_bits_o),
        .chan_a_over_full_scale_o(dao_if_inst.chan_a_over_full_scale_o),
        .chan_b_over_full_scale_o(dao_if_inst.chan_b_over_full_scale_o),
        .data_oe(dao_if_inst.data_oe));

    // Free-running clock
    always #25 ref_clk = ~ref_clk;

    // Compare and count
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Expected word: overrange forces ones, then format flips the top bit
    function automatic logic [10:0] fmt(input logic [9:0] lvl, input logic over, input logic twos);
        logic [10:0] w;
        w = over ? 11'h7ff : {1'b0, lvl};
        fmt = w ^ {1'b0, twos, 9'h000};
    endfunction : fmt

    // Read: wait for the next qualified pair, bounded
    task wait_cap;
        int n;
        n = 0;
        @(negedge ref_clk);
        while (cap_valid !== 1'b1 && n < 80)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 80)
        begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        end
    endtask : wait_cap

    // Write levels, re-phase, swap levels after the first sample edge, read two pairs
    task run_case(input logic tw, input logic [9:0] a, input logic oa, input logic [9:0] b,
                  input logic ob);
        @(posedge ref_clk);
        twos_mode <= tw;
        chan_a_level <= a;
        chan_a_above_fs <= oa;
        chan_b_level <= b;
        chan_b_above_fs <= ob;
        repeat (3) @(posedge ref_clk);
        resync_req <= 1'b1;
        @(posedge ref_clk);
        resync_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chan_a_level <= 10'h000;
        chan_a_above_fs <= 1'b0;
        chan_b_level <= 10'h000;
        chan_b_above_fs <= 1'b0;
        wait_cap;
        check({5'h00, cap_a_over, cap_a_bits}, {5'h00, fmt(a, oa, tw)});
        check({5'h00, cap_b_over, cap_b_bits}, {5'h00, fmt(b, ob, tw)});
        wait_cap;
        check({5'h00, cap_a_over, cap_a_bits}, {5'h00, fmt(10'h000, 1'b0, tw)});
        $display("Test pair twos=%0d done", tw);
    endtask : run_case

    // Counts and verdict, the single end of the run
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // Main sequence
    initial
    begin
        int  idle_caps;
        logic step_was;
        idle_caps = 0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        // Calibration runs alone; no valid pair before any re-phase
        for (int i = 0; i < 30; i++)
        begin
            @(negedge ref_clk);
            if (cap_valid === 1'b1) idle_caps++;
            if (i == 14) check({15'h0, cal_done}, 16'h0000);
            if (i == 14) check({15'h0, cap_calibrated}, 16'h0000);
        end
        check({15'h0, cal_done}, 16'h0001);
        check({15'h0, cap_calibrated}, 16'h0001);
        check(idle_caps[15:0], 16'h0000);
        step_was = cal_step;
        @(negedge ref_clk);
        check({15'h0, cal_step}, {15'h0, ~step_was});
        $display("Test calibration done");
        run_case(1'b0, 10'h155, 1'b0, 10'h2aa, 1'b0);
        run_case(1'b1, 10'h155, 1'b0, 10'h0f0, 1'b0);
        // Float the data pins, then restore them
        @(posedge ref_clk);
        float_outputs <= 1'b1;
        repeat (4) @(negedge ref_clk);
        // Last driven pair is a two's complement zero: 200 with overrange clear
        check({15'h0, dao_if_inst.data_oe}, 16'h0000);
        check({6'h00, dao_if_inst.chan_a_sample_bits}, 16'h01ff);
        check({15'h0, dao_if_inst.chan_b_over_full_scale}, 16'h0001);
        @(posedge ref_clk);
        float_outputs <= 1'b0;
        $display("Test float done");
        run_case(1'b0, 10'h0c3, 1'b1, 10'h321, 1'b0);
        run_case(1'b1, 10'h001, 1'b0, 10'h17e, 1'b1);
        print_verdict;
    end

    // Watchdog: tests need well under a thousand clocks
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        $display("Watchdog expired at %0t", $time);
        print_verdict;
    end
endmodule : tb_top
